// ---- rtl/cims_pkg.sv ----
// constants and types for the contact input mode selector
package cims_pkg;
    localparam int CIMS_MODE_W = 4;
    localparam int CIMS_SPEED_W = 12;
    localparam int CIMS_TIME_W = 14;
    localparam logic [3:0] CIMS_MODE_DEFAULT = 4'h0;
    localparam logic [3:0] CIMS_MODE_MAX = 4'hd;
    localparam logic [3:0] CIMS_MODE_TORQUE = 4'h2;
    localparam logic [3:0] CIMS_MODE_CS_STOP = 4'h3;
    localparam logic [3:0] CIMS_MODE_CS_ANALOG = 4'h4;
    localparam logic [3:0] CIMS_MODE_CS_PULSE = 4'h5;
    localparam logic [3:0] CIMS_MODE_CS_TORQUE = 4'h6;
    localparam logic [3:0] CIMS_MODE_POS_TORQUE = 4'h8;
    localparam logic [3:0] CIMS_MODE_PARAM_POS = 4'hc;
    localparam logic [1:0] CIMS_SEL_NONE = 2'h0;
    localparam logic [1:0] CIMS_SEL_ONE = 2'h1;
    localparam logic [1:0] CIMS_SEL_TWO = 2'h3;
    localparam logic [1:0] CIMS_SEL_THREE = 2'h2;
    localparam int CIMS_FILTER_CYCLES = 4;
    localparam int CIMS_RAMP_REF_RPM = 1000;
    localparam int CIMS_CLOCK_HZ = 100_000_000;
    localparam int CIMS_MS_PER_S = 1000;
    localparam int CIMS_CYCLES_PER_MS = CIMS_CLOCK_HZ / CIMS_MS_PER_S;
    localparam logic [11:0] CIMS_SPEED_ZERO = 12'h000;
    typedef enum logic [2:0] {
        CIMS_SRC_STOP = 3'b000,
        CIMS_SRC_PRESET = 3'b001,
        CIMS_SRC_ANALOG_SPEED = 3'b010,
        CIMS_SRC_PULSE_POS = 3'b011,
        CIMS_SRC_ANALOG_TORQUE = 3'b100,
        CIMS_SRC_OTHER = 3'b101
    } cims_src_type;
endpackage

// ---- rtl/cims_filter.sv ----
// two-flop synchroniser and stable-count debounce for one contact
`timescale 1ns/1ps
module cims_filter
    import cims_pkg::*;
#(
    parameter int FILTER_CYCLES = CIMS_FILTER_CYCLES
) (
    input wire logic clock, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic contact_n, // raw contact, active low
    output logic active // filtered logical level
);
    localparam int CW = $clog2(FILTER_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(FILTER_CYCLES - 1);
    logic meta_reg, meta_next; // first stage, read only by sync
    logic sync_reg, sync_next; // second stage
    logic [CW-1:0] cnt_reg, cnt_next; // cycles the new level has held
    logic act_reg, act_next; // accepted level

    // contact low means active; only accept after it holds steady
    always_comb begin
        meta_next = ~contact_n;
        sync_next = meta_reg;
        cnt_next = '0;
        act_next = act_reg;
        if (sync_reg != act_reg) begin
            if (cnt_reg == CNT_LAST) begin
                act_next = sync_reg;
            end else begin
                cnt_next = cnt_reg + CW'(1);
            end
        end
    end

    // idle contact reads inactive at reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            cnt_reg <= '0;
            act_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            cnt_reg <= cnt_next;
            act_reg <= act_next;
        end
    end

    assign active = act_reg;
endmodule

// ---- rtl/cims_mode_select.sv ----
// contact input decode and mode select with preset speed soft-start
`timescale 1ns/1ps
module cims_mode_select
    import cims_pkg::*;
#(
    parameter int SPEED_W = CIMS_SPEED_W,
    parameter int TIME_W = CIMS_TIME_W,
    parameter int FILTER_CYCLES = CIMS_FILTER_CYCLES,
    parameter int CYCLES_PER_MS = CIMS_CYCLES_PER_MS
) (
    input wire logic clock, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic speed_sel_1_fwd_limit_n, // contact, active low
    input wire logic speed_sel_2_rev_limit_n, // contact, active low
    input wire logic direction_prop_ctrl_n, // contact, active low
    input wire logic [CIMS_MODE_W-1:0] control_mode_setting, // 0..13
    input wire logic analog_speed_limit_enable, // use analog ref as limit
    input wire logic [SPEED_W-1:0] torque_mode_speed_limit, // rpm
    input wire logic [SPEED_W-1:0] max_motor_speed, // rpm
    input wire logic [SPEED_W-1:0] preset_speed_one, // rpm
    input wire logic [SPEED_W-1:0] preset_speed_two, // rpm
    input wire logic [SPEED_W-1:0] preset_speed_three, // rpm
    input wire logic [TIME_W-1:0] accel_ramp_time, // ms to 1000 rpm
    input wire logic [TIME_W-1:0] decel_ramp_time, // ms from 1000 rpm
    output logic [CIMS_MODE_W-1:0] active_mode, // mode in force
    output logic [2:0] reference_source, // cims_src_type code
    output logic [SPEED_W-1:0] speed_command, // ramped preset speed
    output logic reverse_rotation, // reverse preset running
    output logic fwd_torque_limit_req, // external fwd limit
    output logic rev_torque_limit_req, // external rev limit
    output logic fwd_ref_search, // look for reference forward
    output logic rev_ref_search, // look for reference reverse
    output logic prop_ctrl_select, // p instead of pi / clamp / changeover
    output logic analog_speed_limit_active, // analog ref limits speed
    output logic [SPEED_W-1:0] torque_speed_limit // internal speed clamp
);
    // timing through the block, counted in clock edges:
    // two edges of synchroniser on each contact,
    // then the debounce count must see the new level steady,
    // then one edge of decode into the output registers.
    // a mode change alone costs one edge into mode_reg
    // and one more before the decode follows it.
    // the three contacts share one filter length, so a host that
    // moves several contacts together sees them land together;
    // a skewed host may show one intermediate code for a cycle.
    // limitation: a preset change while ramping does not restart the step
    // counter, which restarts only after each step, at the goal, on a zero ramp or off preset speed, so the first step
    // after a goal change may come early by up to one step time.
    // limitation: the ramp moves one rpm per step, which keeps the
    // arithmetic to a counter at the cost of resolution when the
    // ramp setting is short and the clock is slow.

    // filtered logical contacts, one means active
    logic sel1; // speed select one, logical
    logic sel2; // speed select two, logical
    logic dir; // direction / proportional contact, logical
    // mode in force; out-of-range requests never land here
    logic [CIMS_MODE_W-1:0] mode_reg; // registered mode
    logic [CIMS_MODE_W-1:0] mode_next; // mode for next edge
    // reference source decoded from mode and contacts
    cims_src_type src_reg; // registered source
    cims_src_type src_next; // source for next edge
    // preset chosen by the selectors, already clamped
    logic [SPEED_W-1:0] target_reg; // ramp goal
    logic [SPEED_W-1:0] target_next; // next ramp goal
    // ramped speed handed to the speed loop
    logic [SPEED_W-1:0] speed_reg; // present ramp value
    logic [SPEED_W-1:0] speed_next; // next ramp value
    // rotation direction while a preset runs
    logic rev_reg; // registered reverse
    logic rev_next; // next reverse
    // external torque limit requests
    logic fwd_lim_reg; // forward limit, registered
    logic fwd_lim_next; // forward limit, next
    logic rev_lim_reg; // reverse limit, registered
    logic rev_lim_next; // reverse limit, next
    // reference point search switches
    logic fwd_srch_reg; // forward search, registered
    logic fwd_srch_next; // forward search, next
    logic rev_srch_reg; // reverse search, registered
    logic rev_srch_next; // reverse search, next
    // direction contact used for proportional, clamp or changeover
    logic prop_reg; // registered selection
    logic prop_next; // next selection
    // analog speed limit qualifier
    logic alim_reg; // registered qualifier
    logic alim_next; // next qualifier
    // internal torque-mode speed clamp
    logic [SPEED_W-1:0] tlim_reg; // registered clamp
    logic [SPEED_W-1:0] tlim_next; // next clamp
    // soft-start step counter; wide enough for the longest ramp at full clock
    logic [31:0] acc_reg; // cycles since last step
    logic [31:0] acc_next; // next count
    // selector pair as {sel1, sel2}
    logic [1:0] code; // selector code
    // cycles between one rpm steps for the ramp in use
    logic [31:0] ramp_cycles; // step period
    // ramp setting picked by the direction of change
    logic [TIME_W-1:0] ramp_ms; // accel or decel setting

    // one filter per contact; the same debounce on all three keeps them aligned
    logic [2:0] raw_n, act;
    assign raw_n = {direction_prop_ctrl_n, speed_sel_2_rev_limit_n, speed_sel_1_fwd_limit_n};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_filt
            cims_filter #(
                .FILTER_CYCLES(FILTER_CYCLES)
            ) u_filt (
                .clock(clock),
                .resetn(resetn),
                .contact_n(raw_n[gi]),
                .active(act[gi])
            );
        end
    endgenerate
    assign sel1 = act[0];
    assign sel2 = act[1];
    assign dir = act[2];
    assign code = {sel1, sel2};

    // contact-speed modes are 3..6
    function automatic logic is_contact_speed(input logic [CIMS_MODE_W-1:0] m);
        is_contact_speed = (m >= CIMS_MODE_CS_STOP) && (m <= CIMS_MODE_CS_TORQUE);
    endfunction

    // out-of-range presets fall back to the motor maximum
    function automatic logic [SPEED_W-1:0] clamp_speed(input logic [SPEED_W-1:0] s,
                                                      input logic [SPEED_W-1:0] mx);
        clamp_speed = (s > mx) ? mx : s;
    endfunction

    // decode contacts against the mode
    always_comb begin
        // out-of-range setting keeps the previous mode rather than guessing
        mode_next = (control_mode_setting <= CIMS_MODE_MAX) ? control_mode_setting : mode_reg;
        src_next = CIMS_SRC_OTHER;
        target_next = CIMS_SPEED_ZERO;
        rev_next = 1'b0;
        fwd_lim_next = 1'b0;
        rev_lim_next = 1'b0;
        fwd_srch_next = 1'b0;
        rev_srch_next = 1'b0;
        prop_next = 1'b0;
        alim_next = 1'b0;
        tlim_next = torque_mode_speed_limit;
        if (is_contact_speed(mode_reg)) begin
            // selectors never act as torque limits here
            case (code)
                CIMS_SEL_ONE: begin
                    src_next = CIMS_SRC_PRESET;
                    target_next = clamp_speed(preset_speed_one, max_motor_speed);
                    rev_next = dir;
                end
                CIMS_SEL_TWO: begin
                    src_next = CIMS_SRC_PRESET;
                    target_next = clamp_speed(preset_speed_two, max_motor_speed);
                    rev_next = dir;
                end
                CIMS_SEL_THREE: begin
                    src_next = CIMS_SRC_PRESET;
                    target_next = clamp_speed(preset_speed_three, max_motor_speed);
                    rev_next = dir;
                end
                default: begin
                    // code 00: direction ignored, mode picks the source
                    case (mode_reg)
                        CIMS_MODE_CS_STOP: begin
                            // held at internal speed zero
                            src_next = CIMS_SRC_STOP;
                        end
                        CIMS_MODE_CS_ANALOG: begin
                            // analog speed reference drives
                            src_next = CIMS_SRC_ANALOG_SPEED;
                        end
                        CIMS_MODE_CS_PULSE: begin
                            // pulse train gives position
                            src_next = CIMS_SRC_PULSE_POS;
                        end
                        default: begin
                            // mode 6: analog torque, selectors are not limits
                            src_next = CIMS_SRC_ANALOG_TORQUE;
                        end
                    endcase
                end
            endcase
        end else if (mode_reg == CIMS_MODE_PARAM_POS) begin
            // parameter position: selectors hunt for the reference point
            // and are never torque limits in this mode
            fwd_srch_next = sel1;
            rev_srch_next = sel2;
            prop_next = dir;
        end else begin
            // every remaining mode: selectors are external torque limits,
            // including the torque-only and position/torque modes
            fwd_lim_next = sel1;
            rev_lim_next = sel2;
            case (mode_reg)
                CIMS_MODE_TORQUE: begin
                    src_next = CIMS_SRC_ANALOG_TORQUE;
                end
                CIMS_MODE_POS_TORQUE: begin
                    src_next = dir ? CIMS_SRC_ANALOG_TORQUE : CIMS_SRC_PULSE_POS;
                end
                default: begin
                    prop_next = dir;
                end
            endcase
        end
        // analog limit only matters while torque is the reference
        if (src_next == CIMS_SRC_ANALOG_TORQUE) begin
            alim_next = analog_speed_limit_enable;
        end
    end

    // soft start: step the speed by one rpm every ramp_ms*cycles/1000 cycles
    always_comb begin
        ramp_ms = (target_reg > speed_reg) ? accel_ramp_time : decel_ramp_time;
        ramp_cycles = (32'(ramp_ms) * 32'(CYCLES_PER_MS)) / 32'(CIMS_RAMP_REF_RPM);
        speed_next = speed_reg;
        acc_next = 32'h0000_0000;
        if (src_reg != CIMS_SRC_PRESET) begin
            // leaving preset speed drops the ramp; other sources own the motor
            speed_next = CIMS_SPEED_ZERO;
        end else if (target_reg == speed_reg) begin
            acc_next = 32'h0000_0000;
        end else if (ramp_ms == '0) begin
            speed_next = target_reg;
        end else if (acc_reg + 32'h0000_0001 >= ramp_cycles) begin
            // trade-off: one rpm per step keeps arithmetic to a counter
            speed_next = (target_reg > speed_reg) ? speed_reg + SPEED_W'(1) : speed_reg - SPEED_W'(1);
        end else begin
            acc_next = acc_reg + 32'h0000_0001;
        end
    end

    // registers for decode and ramp state
    // reset leaves every request off and the mode at its default,
    // so a drive powering up with closed contacts does not move
    // until the filters have seen the contacts held
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            // mode at its default, source not yet decoded
            mode_reg <= CIMS_MODE_DEFAULT;
            src_reg <= CIMS_SRC_OTHER;
            target_reg <= CIMS_SPEED_ZERO;
            speed_reg <= CIMS_SPEED_ZERO;
            rev_reg <= 1'b0;
            fwd_lim_reg <= 1'b0;
            rev_lim_reg <= 1'b0;
            fwd_srch_reg <= 1'b0;
            rev_srch_reg <= 1'b0;
            prop_reg <= 1'b0;
            alim_reg <= 1'b0;
            tlim_reg <= CIMS_SPEED_ZERO;
            acc_reg <= 32'h0000_0000;
        end else begin
            // plain registering; all decisions live in the comb blocks
            mode_reg <= mode_next;
            src_reg <= src_next;
            target_reg <= target_next;
            speed_reg <= speed_next;
            rev_reg <= rev_next;
            fwd_lim_reg <= fwd_lim_next;
            rev_lim_reg <= rev_lim_next;
            fwd_srch_reg <= fwd_srch_next;
            rev_srch_reg <= rev_srch_next;
            prop_reg <= prop_next;
            alim_reg <= alim_next;
            tlim_reg <= tlim_next;
            acc_reg <= acc_next;
        end
    end

    // all outputs from flip-flops
    // no output is combinational, so the far side never sees a
    // decode glitch while a contact and the mode move together
    assign active_mode = mode_reg;
    assign reference_source = src_reg;
    assign speed_command = speed_reg;
    assign reverse_rotation = rev_reg;
    assign fwd_torque_limit_req = fwd_lim_reg;
    assign rev_torque_limit_req = rev_lim_reg;
    assign fwd_ref_search = fwd_srch_reg;
    assign rev_ref_search = rev_srch_reg;
    assign prop_ctrl_select = prop_reg;
    assign analog_speed_limit_active = alim_reg;
    assign torque_speed_limit = tlim_reg;
endmodule

// ---- dv/cims_mode_select_monitor.sv ----
// assertions on the decoded outputs of the contact input mode selector
`timescale 1ns/1ps
module cims_mode_select_monitor
    import cims_pkg::*;
#(
    parameter int SPEED_W = CIMS_SPEED_W
) (
    input wire logic clock, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic speed_sel_1_fwd_limit_n, // contact 1
    input wire logic speed_sel_2_rev_limit_n, // contact 2
    input wire logic direction_prop_ctrl_n, // direction contact
    input wire logic [CIMS_MODE_W-1:0] control_mode_setting, // requested mode
    input wire logic analog_speed_limit_enable, // limit enable
    input wire logic [SPEED_W-1:0] max_motor_speed, // speed ceiling
    input wire logic [CIMS_MODE_W-1:0] active_mode, // mode in force
    input wire logic [2:0] reference_source, // source code
    input wire logic [SPEED_W-1:0] speed_command, // ramped speed
    input wire logic reverse_rotation, // reverse run
    input wire logic fwd_torque_limit_req, // fwd limit
    input wire logic rev_torque_limit_req, // rev limit
    input wire logic fwd_ref_search, // fwd search
    input wire logic prop_ctrl_select, // direction use
    input wire logic analog_speed_limit_active // analog limit
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // eight edges cover sync, debounce and decode of a held contact
    sequence s_held(logic c, logic [3:0] m);
        (c && active_mode == m)[*8];
    endsequence
    // decode trails the mode register by one edge
    sequence s_cs_mode;
        (active_mode inside {[4'h3:4'h6]})[*2];
    endsequence
    property p_mode_load; control_mode_setting <= CIMS_MODE_MAX |=> active_mode == $past(control_mode_setting); endproperty
    a_mode_load: assert property (p_mode_load) else $error("mode not loaded");
    property p_mode_hold; control_mode_setting > CIMS_MODE_MAX |=> $stable(active_mode); endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("bad mode taken");
    property p_cs_sel; s_cs_mode |-> !fwd_torque_limit_req && !rev_torque_limit_req && !fwd_ref_search; endproperty
    a_cs_sel: assert property (p_cs_sel) else $error("selector misused");
    property p_search; s_held(!speed_sel_1_fwd_limit_n, 4'hc) |=> fwd_ref_search && !fwd_torque_limit_req; endproperty
    a_search: assert property (p_search) else $error("no search");
    property p_limit; s_held(!speed_sel_2_rev_limit_n, 4'h0) |=> rev_torque_limit_req; endproperty
    a_limit: assert property (p_limit) else $error("no limit");
    property p_reverse;
        s_held(!direction_prop_ctrl_n && !speed_sel_2_rev_limit_n, 4'h3) |=> reverse_rotation && reference_source == 3'h1;
    endproperty
    a_reverse: assert property (p_reverse) else $error("no reverse preset");
    property p_stop;
        s_held(speed_sel_1_fwd_limit_n && speed_sel_2_rev_limit_n, 4'h3) |=> reference_source == 3'h0 && speed_command == 0;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop");
    property p_mode2; (active_mode == CIMS_MODE_TORQUE)[*2] |-> !prop_ctrl_select && !reverse_rotation; endproperty
    a_mode2: assert property (p_mode2) else $error("direction used");
    property p_mode8; s_held(!direction_prop_ctrl_n, 4'h8) |=> reference_source == 3'h4; endproperty
    a_mode8: assert property (p_mode8) else $error("no torque");
    property p_aslim; (analog_speed_limit_enable && reference_source == 3'h4)[*2] |-> analog_speed_limit_active; endproperty
    a_aslim: assert property (p_aslim) else $error("no analog limit");
    property p_max; $stable(max_motor_speed) |-> speed_command <= max_motor_speed; endproperty
    a_max: assert property (p_max) else $error("above max");
    property p_debounce; $rose(fwd_torque_limit_req) |-> $past(speed_sel_1_fwd_limit_n, 3) == 1'b0; endproperty
    a_debounce: assert property (p_debounce) else $error("limit on glitch");
endmodule
bind cims_mode_select cims_mode_select_monitor #(.SPEED_W(SPEED_W)) i_cims_mode_select_monitor (.*);

// ---- dv/cims_contact_host.sv ----
// host side contact driver, active low, with commanded chatter
`timescale 1ns/1ps
module cims_contact_host (
    input wire logic clock, // system clock
    input wire logic [2:0] level, // logical sel1, sel2, dir
    input wire logic bounce, // chatter on sel1 while high
    output logic [2:0] contact_n // contact lines
);
    initial contact_n = 3'b111; // open contacts idle high
    // closed contact pulls low, changed off the sampling edge
    always @(negedge clock) begin
        contact_n <= ~level ^ {bounce, 2'b00};
    end
endmodule

// ---- dv/cims_mode_select_tb.sv ----
// self-checking bench for the contact input mode selector
`timescale 1ns/1ps
module cims_mode_select_tb;
    import cims_pkg::*;
    typedef struct packed {
        logic [3:0] mode; // requested mode
        logic [3:0] exp_mode; // mode expected in force
        logic [2:0] lvl; // sel1, sel2, dir
        logic [2:0] src; // expected source, 7 skips
        logic [5:0] flg; // limits, searches, reverse, prop
        logic [11:0] spd; // expected speed
    } cims_row_type;
    logic clock = 1'b0; // 100 MHz
    logic resetn = 1'b0; // low at start
    logic bounce = 1'b0; // chatter command
    logic analog_speed_limit_enable = 1'b0; // toggled per row
    logic [2:0] host_level = 3'b000; // logical contacts
    logic [2:0] contact_n; // contact wires
    logic [3:0] control_mode_setting = 4'h0; // requested mode
    logic [13:0] accel_ramp_time = 14'h0000; // no ramp in table
    logic [13:0] decel_ramp_time = 14'h0000; // no ramp in table
    logic [11:0] torque_mode_speed_limit = 12'h100; // clamp value
    logic [3:0] active_mode; // mode in force
    logic [2:0] reference_source; // decoded source
    logic [11:0] speed_command, torque_speed_limit; // speeds
    logic reverse_rotation, fwd_torque_limit_req, rev_torque_limit_req; // flags
    logic fwd_ref_search, rev_ref_search, prop_ctrl_select, analog_speed_limit_active; // flags
    int error_cnt = 0; // mismatches
    int check_count = 0; // compares
    // preset three is 300 rpm, above the 250 ceiling
    cims_row_type rows [13] = '{'{4'h3, 4'h3, 3'b000, 3'h0, 6'h00, 12'h000},
        '{4'h3, 4'h3, 3'b011, 3'h1, 6'h02, 12'h064}, '{4'h4, 4'h4, 3'b110, 3'h1, 6'h00, 12'h0c8},
        '{4'h5, 4'h5, 3'b101, 3'h1, 6'h02, 12'h0fa}, '{4'h4, 4'h4, 3'b000, 3'h2, 6'h00, 12'h000},
        '{4'h5, 4'h5, 3'b000, 3'h3, 6'h00, 12'h000}, '{4'h6, 4'h6, 3'b001, 3'h4, 6'h00, 12'h000},
        '{4'hc, 4'hc, 3'b101, 3'h7, 6'h09, 12'h000}, '{4'h0, 4'h0, 3'b111, 3'h7, 6'h31, 12'h000},
        '{4'h2, 4'h2, 3'b011, 3'h4, 6'h10, 12'h000}, '{4'h8, 4'h8, 3'b000, 3'h3, 6'h00, 12'h000},
        '{4'h8, 4'h8, 3'b001, 3'h4, 6'h00, 12'h000}, '{4'he, 4'h8, 3'b001, 3'h4, 6'h00, 12'h000}};
    always #5 clock = ~clock; // 10 ns period
    cims_contact_host i_cims_contact_host (.clock(clock), .level(host_level), .bounce(bounce), .contact_n(contact_n));
    cims_mode_select #(.CYCLES_PER_MS(10)) i_cims_mode_select (
        .clock(clock), .resetn(resetn), .speed_sel_1_fwd_limit_n(contact_n[2]),
        .speed_sel_2_rev_limit_n(contact_n[1]), .direction_prop_ctrl_n(contact_n[0]),
        .control_mode_setting(control_mode_setting), .analog_speed_limit_enable(analog_speed_limit_enable),
        .torque_mode_speed_limit(torque_mode_speed_limit), .max_motor_speed(12'h0fa),
        .preset_speed_one(12'h064), .preset_speed_two(12'h0c8), .preset_speed_three(12'h12c),
        .accel_ramp_time(accel_ramp_time), .decel_ramp_time(decel_ramp_time), .active_mode(active_mode),
        .reference_source(reference_source), .speed_command(speed_command), .reverse_rotation(reverse_rotation),
        .fwd_torque_limit_req(fwd_torque_limit_req), .rev_torque_limit_req(rev_torque_limit_req),
        .fwd_ref_search(fwd_ref_search), .rev_ref_search(rev_ref_search), .prop_ctrl_select(prop_ctrl_select),
        .analog_speed_limit_active(analog_speed_limit_active), .torque_speed_limit(torque_speed_limit));
    // one compare, reported at once on mismatch
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // run needs under 2500 cycles, so 5000 means a hang
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        results();
    end
    initial begin
        repeat (10) @(negedge clock);
        check({active_mode, reference_source, speed_command[4:0]}, 12'h0a0);
        resetn = 1'b1;
        $display("reset test done");
        // table rows, enable alternates so both limit states show
        foreach (rows[i]) begin
            @(negedge clock);
            control_mode_setting = rows[i].mode;
            host_level = rows[i].lvl;
            analog_speed_limit_enable = i[0];
            torque_mode_speed_limit = 12'(i) + 12'h100;
            repeat (12) @(negedge clock);
            check(12'(active_mode), 12'(rows[i].exp_mode));
            check(12'({fwd_torque_limit_req, rev_torque_limit_req, fwd_ref_search, rev_ref_search,
                reverse_rotation, prop_ctrl_select}), 12'(rows[i].flg));
            check(speed_command, rows[i].spd);
            check(torque_speed_limit, torque_mode_speed_limit);
            if (rows[i].src != 3'h7) begin
                check(12'(reference_source), 12'(rows[i].src));
                check(12'(analog_speed_limit_active), 12'(i[0] && rows[i].src == 3'h4));
            end
            $display("row %0d test done", i);
        end
        // two-cycle chatter on sel1 must not reach the limit output
        control_mode_setting = 4'h0;
        host_level = 3'b000;
        repeat (12) @(negedge clock);
        bounce = 1'b1;
        repeat (2) @(negedge clock);
        bounce = 1'b0;
        repeat (12) @(negedge clock);
        check(12'(fwd_torque_limit_req), 12'h000);
        $display("chatter test done");
        // 1000 ms per 1000 rpm at 10 cycles per ms: 10 cycles per rpm
        accel_ramp_time = 14'd1000;
        control_mode_setting = 4'h3;
        host_level = 3'b010;
        repeat (400) @(negedge clock);
        check(12'(speed_command > 12'h01e && speed_command < 12'h02d), 12'h001);
        for (int k = 0; k < 1000 && speed_command !== 12'h064; k++) @(negedge clock);
        check(speed_command, 12'h064);
        // zero accel jumps to preset two, then 500 ms decel: 5 cycles per rpm
        accel_ramp_time = 14'd0;
        host_level = 3'b110;
        repeat (12) @(negedge clock);
        check(speed_command, 12'h0c8);
        decel_ramp_time = 14'd500;
        host_level = 3'b010;
        repeat (400) @(negedge clock);
        check(12'(speed_command > 12'h06e && speed_command < 12'h08c), 12'h001);
        for (int k = 0; k < 1000 && speed_command !== 12'h064; k++) @(negedge clock);
        check(speed_command, 12'h064);
        $display("ramp test done");
        results();
    end
endmodule
